// *** design/port_set_consts.vh ***
// Purpose: Shared constants of the parallel port set.
// Assumes: Port addresses are the CPU port-access numbers.
// Notes:   Definitions only.
`ifndef PORT_SET_CONSTS_VH
`define PORT_SET_CONSTS_VH
`define ADDR_W            4
`define ADDR_INPUT        4'h0
`define ADDR_OUT_LOW      4'h1
`define ADDR_OUT_HIGH     4'h2
`define ADDR_PWM_SHARED   4'h4
`define ADDR_BIDIR_A      4'h5
`define ADDR_TRISTATE     4'h6
`define ADDR_BIDIR_B      4'h7
`define ADDR_IRQ_TIMER    4'h8
`define ADDR_COMPARATOR   4'h9
`define ADDR_HOLD_STATUS  4'he
`define LATCH_RESET4      4'hf
`define LATCH_RESET3      3'h7
`define OUT_RESET4        4'h0
`define TRI_EN_BIT        3
`define CMP_INPUT_BIT     2
`define CMP_STATUS_BIT    3
`define IRQ_T1_BIT        3
`define IRQ_I1_BIT        2
`define IRQ_T2_BIT        1
`define IRQ_I2_BIT        0
`endif

// *** design/pin_sync.v ***
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Input is asynchronous to clk_sys.
// Notes:   Output changes only when stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             rstn,
  input  wire             ce,
  // Data
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] level
);
  reg [WIDTH-1:0] s1;
  reg [WIDTH-1:0] s2;
  reg [WIDTH-1:0] s3;
  integer i;
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s1    <= {WIDTH{1'b1}};
      s2    <= {WIDTH{1'b1}};
      s3    <= {WIDTH{1'b1}};
      level <= {WIDTH{1'b1}};
    end
    else if (ce)
    begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      for (i = 0; i < WIDTH; i = i + 1)
        if (s2[i] == s3[i])
          level[i] <= s3[i];
    end
  end
endmodule
`default_nettype wire

// *** design/shared_io_port_set.v ***
// Purpose: Latched port set of a 4-bit controller with shared pin functions.
// Assumes: CPU port strobes are one-cycle pulses on clk_sys.
// Notes:   Open-drain pins are released (oe low) when latch is 1, driven low when 0.
//
// Contract
// - The 5-to-8 conversion write loads output_port_low and output_port_high together as one 8-bit value.
// - Pwm-shared bit 0 carries the wide converter output and bits 3..1 the narrow ones.
// - Each bit of a latched bidirectional port can be set or cleared alone by bit index.
// - Irq/timer bit 3 feeds counter one, bit 2 irq one, bit 1 counter two, bit 0 irq two.
// - The comparator-shared port is 3 bits with latches and bit 2 feeds the comparator.
// - With the tri-state option the tri-state port buffers share one enable.
// - A 1-bit sense input shared with the hold request is readable by software.
// - The top bit of the port nine output control enables the tri-state buffers, 0 floats them.
// - Reset clears the tri-state enable to 0.
// - Reset sets the pwm-shared and comparator-shared latches to all ones.
`timescale 1ns/100ps
`default_nettype none
`include "port_set_consts.vh"
module shared_io_port_set (
  // Clock, reset, enable
  input  wire       clk_sys,
  input  wire       rstn,
  input  wire       ce,
  // Configuration
  input  wire       tristate_circuit_option,
  // CPU port access
  input  wire [3:0] port_addr,
  input  wire [3:0] wr_data,
  input  wire       wr_en,
  input  wire       bit_set,
  input  wire       bit_clr,
  input  wire [1:0] bit_index,
  input  wire [7:0] conv_data,
  input  wire       conv_wr,
  input  wire       rd_en,
  output reg  [3:0] rd_data,
  output reg        rd_valid,
  // Dedicated input and sense pins
  input  wire [3:0] dedicated_input_port,
  input  wire       hold_sense_pin,
  // Output ports
  output reg  [3:0] output_port_low,
  output reg  [3:0] output_port_high,
  // Bidirectional pins: input level, output value, enable
  input  wire [3:0] pwm_shared_in,
  output reg  [3:0] pwm_shared_out,
  output reg  [3:0] pwm_shared_oe,
  input  wire [3:0] bidir_a_in,
  output reg  [3:0] bidir_a_out,
  output reg  [3:0] bidir_a_oe,
  input  wire [3:0] tristate_in,
  output reg  [3:0] tristate_out,
  output reg  [3:0] tristate_oe,
  input  wire [3:0] bidir_b_in,
  output reg  [3:0] bidir_b_out,
  output reg  [3:0] bidir_b_oe,
  input  wire [3:0] irq_timer_in,
  output reg  [3:0] irq_timer_out,
  output reg  [3:0] irq_timer_oe,
  input  wire [2:0] comparator_in,
  output reg  [2:0] comparator_out,
  output reg  [2:0] comparator_oe,
  // Peripheral side
  input  wire       pwm_wide_output,
  input  wire       pwm_narrow_output_a,
  input  wire       pwm_narrow_output_b,
  input  wire       pwm_narrow_output_c,
  input  wire       afc_comparator_result,
  output reg        ext_irq_one,
  output reg        ext_irq_two,
  output reg        counter_one_input,
  output reg        counter_two_input,
  output reg        afc_comparator_input
);
  ////////////////////////////////////////////////////////////////////////////
  reg  [3:0] latch_pwm;
  reg  [3:0] latch_a;
  reg  [3:0] latch_tri;
  reg  [3:0] latch_b;
  reg  [3:0] latch_irq;
  wire [2:0] latch_cmp;
  reg  [3:0] port_nine_output_control;
  wire [3:0] s_in;
  wire [3:0] s_pwm;
  wire [3:0] s_a;
  wire [3:0] s_tri;
  wire [3:0] s_b;
  wire [3:0] s_irq;
  wire [2:0] s_cmp;
  wire       s_hold;
  wire [3:0] pwm_drive;
  reg  [3:0] next_rd;

  // Port nine is one word: bits 2..0 are the comparator-shared latches, bit 3 the tri-state enable.
  assign latch_cmp = port_nine_output_control[2:0];

  // Every pin passes the agreement filter before software or a peripheral sees it.
  pin_sync #(.WIDTH(4)) u_sync_in  (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
    .pin_in(dedicated_input_port), .level(s_in));
  pin_sync #(.WIDTH(4)) u_sync_pwm (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
    .pin_in(pwm_shared_in), .level(s_pwm));
  pin_sync #(.WIDTH(4)) u_sync_a   (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
    .pin_in(bidir_a_in), .level(s_a));
  pin_sync #(.WIDTH(4)) u_sync_tri (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
    .pin_in(tristate_in), .level(s_tri));
  pin_sync #(.WIDTH(4)) u_sync_b   (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
    .pin_in(bidir_b_in), .level(s_b));
  pin_sync #(.WIDTH(4)) u_sync_irq (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
    .pin_in(irq_timer_in), .level(s_irq));
  pin_sync #(.WIDTH(3)) u_sync_cmp (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
    .pin_in(comparator_in), .level(s_cmp));
  pin_sync #(.WIDTH(1)) u_sync_hld (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
    .pin_in(hold_sense_pin), .level(s_hold));

  ////////////////////////////////////////////////////////////////////////////
  // A PWM output that idles high needs the latch at 1; either one low pulls the pin low.
  assign pwm_drive = latch_pwm & {pwm_narrow_output_c, pwm_narrow_output_b,
                                  pwm_narrow_output_a, pwm_wide_output};

  // Applies a whole-nibble write, or a single-bit set/clear, to one latch.
  function [3:0] upd;
    input [3:0] cur;
    input       hit;
    begin
      upd = cur;
      if (hit && wr_en)
        upd = wr_data;
      else if (hit && bit_set)
        upd[bit_index] = 1'b1;
      else if (hit && bit_clr)
        upd[bit_index] = 1'b0;
    end
  endfunction

  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      output_port_low          <= `OUT_RESET4;
      output_port_high         <= `OUT_RESET4;
      latch_pwm                <= `LATCH_RESET4;
      latch_a                  <= `LATCH_RESET4;
      latch_tri                <= `LATCH_RESET4;
      latch_b                  <= `LATCH_RESET4;
      latch_irq                <= `LATCH_RESET4;
      port_nine_output_control <= {1'b0, `LATCH_RESET3};
    end
    else if (ce)
    begin
      if (conv_wr)
      begin
        output_port_low  <= conv_data[3:0];
        output_port_high <= conv_data[7:4];
      end
      else
      begin
        output_port_low  <= upd(output_port_low, port_addr == `ADDR_OUT_LOW);
        output_port_high <= upd(output_port_high, port_addr == `ADDR_OUT_HIGH);
      end
      latch_pwm <= upd(latch_pwm, port_addr == `ADDR_PWM_SHARED);
      latch_a   <= upd(latch_a, port_addr == `ADDR_BIDIR_A);
      latch_tri <= upd(latch_tri, port_addr == `ADDR_TRISTATE);
      latch_b   <= upd(latch_b, port_addr == `ADDR_BIDIR_B);
      latch_irq <= upd(latch_irq, port_addr == `ADDR_IRQ_TIMER);
      // Port nine bits 2..0 drive the pins; bit 3 is the tri-state enable.
      port_nine_output_control <= upd(port_nine_output_control, port_addr == `ADDR_COMPARATOR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pwm_shared_out <= 4'h0;
      pwm_shared_oe  <= 4'h0;
      bidir_a_out    <= 4'h0;
      bidir_a_oe     <= 4'h0;
      tristate_out   <= 4'h0;
      tristate_oe    <= 4'h0;
      bidir_b_out    <= 4'h0;
      bidir_b_oe     <= 4'h0;
      irq_timer_out  <= 4'h0;
      irq_timer_oe   <= 4'h0;
      comparator_out <= 3'h0;
      comparator_oe  <= 3'h0;
    end
    else if (ce)
    begin
      // Open-drain style: only a 0 is driven, a 1 lets the pin float.
      pwm_shared_out <= 4'h0;
      pwm_shared_oe  <= ~pwm_drive;
      bidir_a_out    <= 4'h0;
      bidir_a_oe     <= ~latch_a;
      bidir_b_out    <= 4'h0;
      bidir_b_oe     <= ~latch_b;
      irq_timer_out  <= 4'h0;
      irq_timer_oe   <= ~latch_irq;
      comparator_out <= 3'h0;
      comparator_oe  <= ~latch_cmp;
      if (tristate_circuit_option)
      begin
        // One enable for the whole port; driven both ways while it is on.
        tristate_out <= latch_tri;
        tristate_oe  <= {4{port_nine_output_control[`TRI_EN_BIT]}};
      end
      else
      begin
        tristate_out <= 4'h0;
        tristate_oe  <= ~latch_tri;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_irq_one          <= 1'b1;
      ext_irq_two          <= 1'b1;
      counter_one_input    <= 1'b1;
      counter_two_input    <= 1'b1;
      afc_comparator_input <= 1'b1;
    end
    else if (ce)
    begin
      counter_one_input    <= s_irq[`IRQ_T1_BIT];
      ext_irq_one          <= s_irq[`IRQ_I1_BIT];
      counter_two_input    <= s_irq[`IRQ_T2_BIT];
      ext_irq_two          <= s_irq[`IRQ_I2_BIT];
      afc_comparator_input <= s_cmp[`CMP_INPUT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @*
  begin
    case (port_addr)
      `ADDR_INPUT:       next_rd = s_in;
      `ADDR_OUT_LOW:     next_rd = output_port_low;
      `ADDR_OUT_HIGH:    next_rd = output_port_high;
      `ADDR_PWM_SHARED:  next_rd = s_pwm;
      `ADDR_BIDIR_A:     next_rd = s_a;
      `ADDR_TRISTATE:    next_rd = s_tri;
      `ADDR_BIDIR_B:     next_rd = s_b;
      `ADDR_IRQ_TIMER:   next_rd = s_irq;
      `ADDR_COMPARATOR:  next_rd = {afc_comparator_result, s_cmp};
      `ADDR_HOLD_STATUS: next_rd = {3'h0, s_hold};
      default:           next_rd = 4'h0;
    endcase
  end

  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data  <= 4'h0;
      rd_valid <= 1'b0;
    end
    else if (ce)
    begin
      rd_valid <= rd_en;
      if (rd_en)
        rd_data <= next_rd;
    end
  end
endmodule
`default_nettype wire

// *** dv/port_set_properties.sv ***
// Purpose: Timing relations at the ports of the port set.
// Assumes: One clock domain and an asynchronous active-low reset.
// Notes:   Pin checks wait for the input synchroniser to settle.
`timescale 1ns/100ps
`default_nettype none
module port_set_properties (
  // Clock and control
  input wire logic       clk_sys, rstn, ce, tristate_circuit_option,
  input wire logic       wr_en, bit_set, conv_wr, rd_en, rd_valid, hold_sense_pin,
  input wire logic [1:0] bit_index,
  input wire logic [3:0] port_addr, rd_data, dedicated_input_port, output_port_low, output_port_high,
  input wire logic [7:0] conv_data,
  // Pins and peripheral side
  input wire logic [3:0] pwm_shared_oe, tristate_oe, bidir_a_oe, irq_timer_in,
  input wire logic [2:0] comparator_in,
  input wire logic       ext_irq_one, ext_irq_two, counter_one_input, counter_two_input, afc_comparator_input
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////////////
  AST_RD_VALID: assert property (rd_en && ce |=> rd_valid) else $error("read answer missing");
  AST_CONV: assert property (conv_wr && ce |=> {output_port_high, output_port_low} == $past(conv_data))
    else $error("conversion output wrong");
  AST_BIT_SET: assert property (bit_set && ce && !wr_en && !conv_wr && port_addr == 4'h5
    |-> ##2 !bidir_a_oe[$past(bit_index, 2)]) else $error("bit set left pin driven");
  AST_IRQ_MAP: assert property (($stable(irq_timer_in) && ce)[*8] |->
    {counter_one_input, ext_irq_one, counter_two_input, ext_irq_two} == irq_timer_in) else $error("irq map wrong");
  AST_CMP_IN: assert property (($stable(comparator_in) && ce)[*8] |-> afc_comparator_input == comparator_in[2])
    else $error("comparator input wrong");
  AST_TRI_JOINT: assert property (tristate_circuit_option && $past(tristate_circuit_option)
    |-> tristate_oe == 4'h0 || tristate_oe == 4'hf) else $error("tri-state enables split");
  AST_RESET_STATE: assert property ($rose(rstn) |-> pwm_shared_oe == 4'h0 && tristate_oe == 4'h0)
    else $error("pins driven after reset");
  AST_DEDICATED: assert property (($stable(dedicated_input_port) && ce)[*6] ##0 (rd_en && port_addr == 4'h0)
    |=> rd_data == $past(dedicated_input_port)) else $error("input port read wrong");
  AST_HOLD: assert property (($stable(hold_sense_pin) && ce)[*6] ##0 (rd_en && port_addr == 4'he)
    |=> rd_data == {3'h0, $past(hold_sense_pin)}) else $error("sense read wrong");
  cover property (conv_wr);
  cover property (tristate_oe == 4'hf);
  cover property (rd_valid && rd_data != 4'h0);
endmodule
bind shared_io_port_set port_set_properties u_props (.*);
`default_nettype wire

// *** dv/pin_board.sv ***
// Purpose: Board side of the bidirectional pins.
// Assumes: Every pin has a pull-up on the board.
// Notes:   A load may pull pins low through ext_low.
`timescale 1ns/100ps
`default_nettype none
module pin_board #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] ext_low,
  output wire logic [W-1:0] level
);
  // A released pin rises to the pull-up, so it never shows a stale driven value.
  assign level = ~(oe & ~out) & ~ext_low;
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Purpose: Self-checking bench of the port set.
// Assumes: Port strobes last one cycle and are driven after a rising edge.
// Notes:   Pin reads allow several cycles for the input synchroniser.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic       clk_sys, rstn, ce, tristate_circuit_option, wr_en, bit_set, bit_clr, conv_wr, rd_en, rd_valid;
  logic       hold_sense_pin, afc_comparator_result, ext_irq_one, ext_irq_two, counter_one_input, counter_two_input;
  logic       pwm_wide_output, pwm_narrow_output_a, pwm_narrow_output_b, pwm_narrow_output_c, afc_comparator_input;
  logic [1:0] bit_index;
  logic [2:0] comparator_out, comparator_oe;
  logic [3:0] port_addr, wr_data, rd_data, dedicated_input_port, output_port_low, output_port_high, ext_low;
  logic [3:0] pwm_shared_out, pwm_shared_oe, bidir_a_out, bidir_a_oe, tristate_out, tristate_oe;
  logic [3:0] bidir_b_out, bidir_b_oe, irq_timer_out, irq_timer_oe;
  wire logic [2:0] comparator_in;
  wire logic [3:0] pwm_shared_in, bidir_a_in, tristate_in, bidir_b_in, irq_timer_in;
  logic [7:0] conv_data;
  logic [23:0] oe_all;
  logic [19:0] rows [6];
  int         err_count, comparisons, cycles;
  //////////////////////////////////////////////////////////////////////////////
  shared_io_port_set u_dut (.*);
  pin_board #(.W(23)) u_board (.oe(oe_all[22:0]), .ext_low({ext_low[2:0], {5{ext_low}}}),
    .out({comparator_out, irq_timer_out, bidir_b_out, tristate_out, bidir_a_out, pwm_shared_out}),
    .level({comparator_in, irq_timer_in, bidir_b_in, tristate_in, bidir_a_in, pwm_shared_in}));
  assign oe_all = {1'b0, comparator_oe, irq_timer_oe, bidir_b_oe, tristate_oe, bidir_a_oe, pwm_shared_oe};
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic op(input logic [3:0] a, input logic [3:0] d, input logic [2:0] kind);
    @(posedge clk_sys);
    port_addr <= a;
    wr_data <= d;
    bit_index <= d[1:0];
    {wr_en, bit_set, bit_clr} <= kind;
    @(posedge clk_sys);
    {wr_en, bit_set, bit_clr} <= 3'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [3:0] e);
    @(posedge clk_sys);
    port_addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk(rd_valid, 1'b1);
    chk(rd_data, e);
  endtask
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      err_count++;
      test_done();
    end
  end
  initial
  begin
    // Rows: port, latch nibble, board pull-downs, expected enables, expected read.
    rows = '{20'h4a05a, 20'h5e11e, 20'h69269, 20'h734c3, 20'h8f50a, 20'h96116};
    {rstn, ce, tristate_circuit_option, wr_en, bit_set, bit_clr, conv_wr, rd_en} = 8'h40;
    {hold_sense_pin, afc_comparator_result, pwm_wide_output, pwm_narrow_output_a} = 4'h3;
    {pwm_narrow_output_b, pwm_narrow_output_c} = 2'h3;
    {port_addr, wr_data, dedicated_input_port, ext_low, bit_index, conv_data} = 26'h0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    cyc(1);
    chk({pwm_shared_oe, comparator_oe, tristate_oe, output_port_low}, 15'h0);
    foreach (rows[i])
    begin
      @(posedge clk_sys);
      ext_low <= rows[i][11:8];
      op(rows[i][19:16], rows[i][15:12], 3'h4);
      cyc(2);
      chk(oe_all[4 * (int'(rows[i][19:16]) - 4) +: 4], rows[i][7:4]);
      cyc(6);
      rd(rows[i][19:16], rows[i][3:0]);
    end
    chk({counter_one_input, ext_irq_one, counter_two_input, ext_irq_two}, 4'he);
    chk(afc_comparator_input, 1'b1);
    op(4'h5, 4'h3, 3'h1);
    cyc(2);
    chk(bidir_a_oe, 4'h9);
    op(4'h5, 4'h3, 3'h2);
    cyc(2);
    chk(bidir_a_oe, 4'h1);
    @(posedge clk_sys);
    tristate_circuit_option <= 1'b1;
    op(4'h9, 4'h3, 3'h2);
    cyc(2);
    chk({tristate_oe, tristate_out}, 8'hf9);
    op(4'h9, 4'h3, 3'h1);
    cyc(2);
    chk(tristate_oe, 4'h0);
    op(4'h4, 4'hf, 3'h4);
    @(posedge clk_sys);
    {pwm_wide_output, pwm_narrow_output_c} <= 2'h0;
    cyc(2);
    chk(pwm_shared_oe, 4'h9);
    @(posedge clk_sys);
    {conv_wr, wr_en, port_addr, wr_data, conv_data} <= {2'h3, 4'h1, 4'h3, 8'h5c};
    @(posedge clk_sys);
    {conv_wr, wr_en} <= 2'h0;
    cyc(1);
    chk({output_port_high, output_port_low}, 8'h5c);
    @(posedge clk_sys);
    {hold_sense_pin, dedicated_input_port} <= 5'h19;
    cyc(6);
    rd(4'he, 4'h1);
    rd(4'h0, 4'h9);
    rd(4'h3, 4'h0);
    // A low clock enable must freeze output_port_low even under a write strobe.
    @(posedge clk_sys);
    ce <= 1'b0;
    op(4'h1, 4'h7, 3'h4);
    cyc(1);
    chk(output_port_low, 4'hc);
    @(posedge clk_sys);
    ce <= 1'b1;
    // A reset in mid-run must undo written latches and a set tri-state enable.
    op(4'h4, 4'h0, 3'h4);
    op(4'h9, 4'h3, 3'h2);
    @(posedge clk_sys);
    rstn <= 1'b0;
    @(posedge clk_sys);
    rstn <= 1'b1;
    cyc(1);
    chk({pwm_shared_oe, comparator_oe, tristate_oe, output_port_low}, 15'h4800);
    test_done();
  end
endmodule
`default_nettype wire
